// File: logic/timer_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - prescaler counts freely, untouched by any clock selection change
// - one prescaler feeds both timers, each selecting its own tap
// - select one enables the timer every clock cycle
// - taps divide by 8, 64, 256 and 1024
// - first count after selecting tap N lands 1 to N cycles later
// - prescaler reset restarts tap timing for both timers
// - count pin sampled every cycle through synchroniser stages
// - select 7 counts rising pin edges, select 6 falling edges
// - pin edge to counter update takes a few clock cycles
// - external pulses bypass the prescaler divider
// - while sync hold mode is set, reset bits stay; with the shared reset bit set, internally clocked timers halt
// - clearing sync hold mode clears both reset bits together
// - writing shared reset bit resets prescaler, self clears unless holding
// - select zero gives no enable, timer stopped

module timer_prescaler
  import tps_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  external_count_pin_i,
  output logic      [1:0]  timer_count_enable_o,
  output logic             async_prescaler_reset_o
);

  typedef struct packed {
    logic                  sync_hold_mode;
    logic                  async_prescaler_reset;
    logic                  shared_prescaler_reset;
    logic [SEL_WIDTH-1:0]  select0;
    logic [SEL_WIDTH-1:0]  select1;
    logic [PRESC_WIDTH-1:0] presc;
    logic [1:0]            enable;
    logic                  ack;
    logic [31:0]           rdata;
  } ctrl_s;

  ctrl_s state;
  ctrl_s next_state;

  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++) begin : g_pin
      count_pin_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (external_count_pin_i[g]),
        .rise_o (pin_rise[g]),
        .fall_o (pin_fall[g])
      );
    end
  endgenerate

  function automatic logic tap_hit(input logic [PRESC_WIDTH-1:0] cnt, input logic [9:0] mask);
    tap_hit = ((cnt & mask) == mask);
  endfunction

  // internal sources halt while the shared reset is held; pin sources do not
  function automatic logic pick_enable(input logic [SEL_WIDTH-1:0] sel,
                                       input logic [PRESC_WIDTH-1:0] cnt,
                                       input logic held,
                                       input logic rise,
                                       input logic fall);
    logic r;
    r = 1'b0;
    unique case (sel)
      SEL_STOPPED:  r = 1'b0;
      SEL_DIRECT:   r = ~held;
      SEL_DIV8:     r = ~held & tap_hit(cnt, MASK_DIV8);
      SEL_DIV64:    r = ~held & tap_hit(cnt, MASK_DIV64);
      SEL_DIV256:   r = ~held & tap_hit(cnt, MASK_DIV256);
      SEL_DIV1024:  r = ~held & tap_hit(cnt, MASK_DIV1024);
      SEL_EXT_FALL: r = fall;
      SEL_EXT_RISE: r = rise;
    endcase
    pick_enable = r;
  endfunction

  logic bus_req;
  logic bus_wr;
  logic wr_ctrl;

  always_comb begin
    next_state = state;
    // ack only on a fresh request, dropped the cycle after it was given
    bus_req = wb_cyc_i & wb_stb_i & ~state.ack;
    bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    wr_ctrl = bus_wr & (wb_adr_i == ADDR_GEN_CTRL);

    next_state.ack = bus_req;

    // reset bits self clear unless hold mode keeps them
    if (wr_ctrl) begin
      next_state.sync_hold_mode         = wb_dat_i[BIT_SYNC_HOLD_MODE];
      next_state.async_prescaler_reset  = wb_dat_i[BIT_ASYNC_PRESCALER_RST];
      next_state.shared_prescaler_reset = wb_dat_i[BIT_SHARED_PRESCALER_RST];
    end else if (!state.sync_hold_mode) begin
      next_state.async_prescaler_reset  = 1'b0;
      next_state.shared_prescaler_reset = 1'b0;
    end

    if (bus_wr && wb_adr_i == ADDR_T0_SELECT) begin
      next_state.select0 = wb_dat_i[SEL_WIDTH-1:0];
    end
    if (bus_wr && wb_adr_i == ADDR_T1_SELECT) begin
      next_state.select1 = wb_dat_i[SEL_WIDTH-1:0];
    end

    // free running; selection writes never touch the count
    if (state.shared_prescaler_reset) begin
      next_state.presc = RST_PRESC;
    end else begin
      next_state.presc = state.presc + 1'b1;
    end

    next_state.enable[0] = pick_enable(state.select0, state.presc, state.shared_prescaler_reset,
                                       pin_rise[0], pin_fall[0]);
    next_state.enable[1] = pick_enable(state.select1, state.presc, state.shared_prescaler_reset,
                                       pin_rise[1], pin_fall[1]);

    next_state.rdata = RST_DATA;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADDR_GEN_CTRL: begin
          next_state.rdata[BIT_SYNC_HOLD_MODE]       = state.sync_hold_mode;
          next_state.rdata[BIT_ASYNC_PRESCALER_RST]  = state.async_prescaler_reset;
          next_state.rdata[BIT_SHARED_PRESCALER_RST] = state.shared_prescaler_reset;
        end
        ADDR_T0_SELECT: next_state.rdata[SEL_WIDTH-1:0] = state.select0;
        ADDR_T1_SELECT: next_state.rdata[SEL_WIDTH-1:0] = state.select1;
        ADDR_STATUS: begin
          next_state.rdata[STAT_PRESC_MSB:STAT_PRESC_LSB]   = state.presc;
          next_state.rdata[STAT_ENABLE_MSB:STAT_ENABLE_LSB] = state.enable;
        end
        default: next_state.rdata = RST_DATA;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= '0;
      state.presc   <= RST_PRESC;
      state.select0 <= RST_SEL;
      state.select1 <= RST_SEL;
      state.rdata   <= RST_DATA;
    end else begin
      state <= next_state;
    end
  end

  assign wb_dat_o                = state.rdata;
  assign wb_ack_o                = state.ack;
  assign timer_count_enable_o    = state.enable;
  assign async_prescaler_reset_o = state.async_prescaler_reset;

endmodule // timer_prescaler

`default_nettype wire

// File: common/tps_pkg.sv
package tps_pkg;

  // byte addresses on the register bus
  localparam logic [3:0] ADDR_GEN_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_T0_SELECT  = 4'h4;
  localparam logic [3:0] ADDR_T1_SELECT  = 4'h8;
  localparam logic [3:0] ADDR_STATUS     = 4'hc;

  // general_timer_control fields
  localparam int BIT_SYNC_HOLD_MODE       = 7;
  localparam int BIT_ASYNC_PRESCALER_RST  = 1;
  localparam int BIT_SHARED_PRESCALER_RST = 0;

  // status fields
  localparam int STAT_PRESC_LSB  = 0;
  localparam int STAT_PRESC_MSB  = 9;
  localparam int STAT_ENABLE_LSB = 16;
  localparam int STAT_ENABLE_MSB = 17;

  localparam int PRESC_WIDTH = 10;
  localparam int SEL_WIDTH   = 3;
  localparam int NUM_TIMERS  = 2;

  // clock_source_select encodings
  localparam logic [2:0] SEL_STOPPED  = 3'h0;
  localparam logic [2:0] SEL_DIRECT   = 3'h1;
  localparam logic [2:0] SEL_DIV8     = 3'h2;
  localparam logic [2:0] SEL_DIV64    = 3'h3;
  localparam logic [2:0] SEL_DIV256   = 3'h4;
  localparam logic [2:0] SEL_DIV1024  = 3'h5;
  localparam logic [2:0] SEL_EXT_FALL = 3'h6;
  localparam logic [2:0] SEL_EXT_RISE = 3'h7;

  // tap masks: a tap fires when all masked prescaler bits are one
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV64   = 10'h03f;
  localparam logic [9:0] MASK_DIV256  = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

  // reset values
  localparam logic [9:0]  RST_PRESC = 10'h000;
  localparam logic [2:0]  RST_SEL   = 3'h0;
  localparam logic [31:0] RST_DATA  = 32'h0000_0000;

endpackage

// File: logic/count_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module count_pin_sync
  import tps_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_s;

  sync_s state;
  sync_s next_state;

  // meta is read only by sync; edges compare the two settled stages
  always_comb begin
    next_state      = state;
    next_state.meta = pin_i;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // one pulse per edge; pins slower than clk/2 give no double hits
  assign rise_o = state.sync & ~state.prev;
  assign fall_o = ~state.sync & state.prev;

endmodule // count_pin_sync

`default_nettype wire

// File: sim/tps_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tps_monitor
  import tps_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  external_count_pin_i,
  input wire logic [1:0]  timer_count_enable_o,
  input wire logic        async_prescaler_reset_o
);
  logic       wr, gwr, halt;
  logic [2:0] s0, s1;
  logic [1:0] en;
  assign wr  = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign gwr = wr && wb_adr_i == ADDR_GEN_CTRL;
  assign en  = timer_count_enable_o;
  // shadow of the selects and of a held shared reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s0   <= RST_SEL;
      s1   <= RST_SEL;
      halt <= 1'b0;
    end else begin
      if (wr && wb_adr_i == ADDR_T0_SELECT) s0 <= wb_dat_i[2:0];
      if (wr && wb_adr_i == ADDR_T1_SELECT) s1 <= wb_dat_i[2:0];
      if (gwr) halt <= wb_dat_i[7] && wb_dat_i[0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  property p_stop; s0 == SEL_STOPPED && $past(s0) == SEL_STOPPED && $past(s0, 2) == SEL_STOPPED |-> !en[0]; endproperty
  a_stop: assert property (p_stop) else $error("stopped timer enabled");
  property p_direct; (s0 == SEL_DIRECT && !halt && !gwr) [*4] |-> en[0]; endproperty
  a_direct: assert property (p_direct) else $error("direct enable missing");
  property p_div8; (en[1] && s1 == SEL_DIV8 && !gwr) ##1 (s1 == SEL_DIV8 && !gwr) [*8] |-> en[1] && !$past(en[1]);
  endproperty
  a_div8: assert property (p_div8) else $error("tap period wrong");
  property p_rise; s0 == SEL_EXT_RISE && $stable(s0) && $rose(external_count_pin_i[0]) |-> ##[2:3] en[0]; endproperty
  a_rise: assert property (p_rise) else $error("rising pin edge lost");
  property p_fall; s1 == SEL_EXT_FALL && $stable(s1) && $fell(external_count_pin_i[1]) |-> ##[2:3] en[1]; endproperty
  a_fall: assert property (p_fall) else $error("falling pin edge lost");
  property p_halt; halt && $past(halt) && $stable(s0) && s0 != SEL_EXT_RISE && s0 != SEL_EXT_FALL |-> !en[0];
  endproperty
  a_halt: assert property (p_halt) else $error("held timer counted");
  property p_release; $fell(halt) && s0 == SEL_DIRECT && s1 == SEL_DIRECT |-> en == 2'h0 ##1 en == 2'h3; endproperty
  a_release: assert property (p_release) else $error("timers not started together");
endmodule // tps_monitor
`default_nettype wire

// File: sim/timer_count_model.sv
`timescale 1ns/1ps
`default_nettype none
module timer_count_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  count_enable_i,
  output logic      [15:0] count0_o,
  output logic      [15:0] count1_o
);
  // the timers behind the block only count on an enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count0_o <= 16'h0000;
      count1_o <= 16'h0000;
    end else begin
      count0_o <= count0_o + 16'(count_enable_i[0]);
      count1_o <= count1_o + 16'(count_enable_i[1]);
    end
  end
endmodule // timer_count_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tps_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, apr;
  logic [3:0]  adr, bsel;
  logic [31:0] wdat, rdat, q;
  logic [1:0]  pin, en;
  logic [15:0] c0, c1, b0, b1;
  int          mismatches = 0, compares = 0, cycles = 0;
  int          dv [4] = '{8, 64, 256, 1024};
  timer_prescaler uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .external_count_pin_i(pin),
    .timer_count_enable_o(en), .async_prescaler_reset_o(apr));
  timer_count_model far (.clk_i(clk_i), .rst_i(rst_i), .count_enable_i(en), .count0_o(c0), .count1_o(c1));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // settle first so a select change never falls inside the window
  task automatic snap(input int n);
    repeat (4) @(posedge clk_i);
    b0 = c0;
    b1 = c1;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic t_regs();
    bus(0, ADDR_GEN_CTRL, 32'h0);
    chk("gen reset", q, RST_DATA);
    bus(1, 4'h2, 32'hff);
    bus(0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task automatic t_direct();
    bus(1, ADDR_T0_SELECT, 32'(SEL_DIRECT));
    bus(1, ADDR_T1_SELECT, 32'(SEL_STOPPED));
    snap(10);
    chk("t0 direct", 32'(c0 - b0), 32'd10);
    chk("t1 stopped", 32'(c1 - b1), 32'd0);
  endtask
  task automatic t_taps();
    for (int i = 0; i < 4; i++) begin
      bus(1, ADDR_T1_SELECT, 32'(SEL_DIV8 + 3'(i)));
      snap(4 * dv[i]);
      chk("t1 tap", 32'(c1 - b1), 32'd4);
      chk("t0 beside tap", 32'(c0 - b0), 32'(4 * dv[i]));
    end
  endtask
  task automatic t_hold();
    bus(1, ADDR_T1_SELECT, 32'(SEL_DIRECT));
    bus(1, ADDR_GEN_CTRL, 32'h83);
    snap(20);
    chk("t0 held", 32'(c0 - b0), 32'd0);
    chk("t1 held", 32'(c1 - b1), 32'd0);
    bus(0, ADDR_GEN_CTRL, 32'h0);
    chk("gen held", q, 32'h83);
    chk("async held", 32'(apr), 32'h1);
    bus(1, ADDR_GEN_CTRL, 32'h0);
    snap(10);
    chk("t0 released", 32'(c0 - b0), 32'd10);
    chk("t1 released", 32'(c1 - b1), 32'd10);
    chk("async released", 32'(apr), 32'h0);
    bus(1, ADDR_GEN_CTRL, 32'h01);
    bus(0, ADDR_GEN_CTRL, 32'h0);
    chk("shared reset self clear", q, 32'h0);
    bus(0, ADDR_STATUS, 32'h0);
    // count restarted at the reset pulse: four cycles later, both direct enables high
    chk("prescaler restarted", q, 32'h0003_0004);
  endtask
  // pins stay steady around select writes; halves of four cycles
  task automatic t_ext();
    bus(1, ADDR_T0_SELECT, 32'(SEL_EXT_RISE));
    bus(1, ADDR_T1_SELECT, 32'(SEL_EXT_FALL));
    snap(0);
    repeat (10) begin
      repeat (4) @(posedge clk_i);
      pin <= ~pin;
    end
    repeat (6) @(posedge clk_i);
    chk("t0 rising", 32'(c0 - b0), 32'd5);
    chk("t1 falling", 32'(c1 - b1), 32'd5);
  endtask
  initial begin
    rst_i = 1'b1;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 4'h0;
    bsel  = 4'hf;
    wdat  = 32'h0;
    pin   = 2'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_direct();
    t_taps();
    t_hold();
    t_ext();
    results();
  end
endmodule // tb
bind timer_prescaler tps_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .external_count_pin_i(external_count_pin_i), .timer_count_enable_o(timer_count_enable_o),
  .async_prescaler_reset_o(async_prescaler_reset_o));
`default_nettype wire
